// file: verilog/ptsl_teach.sv
`timescale 1ns/100ps
module ptsl_teach #(
  parameter int HOLD_CYCLES     = ptsl_pkg::HOLD_CYC,      // Arm hold time
  parameter int OPEN_CYCLES     = ptsl_pkg::OPEN_CYC,      // Release time
  parameter int WINDOW_CYCLES   = ptsl_pkg::WINDOW_CYC,    // Teach window
  parameter int DEBOUNCE_CYCLES = ptsl_pkg::DEBOUNCE_CYC   // Contact settle
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // Teach contacts: zero (pin 2-3 or zero button), end (pin 1-2 or span)
  input  wire logic        zero_contact,
  input  wire logic        end_contact,
  // Measurement front end
  input  wire logic        element_seen,
  input  wire logic        element_blind,
  input  wire logic [15:0] element_pos,
  input  wire logic [7:0]  echo_level,
  // Status lamp
  output logic             lamp_green,
  output logic             lamp_yellow,
  output logic             lamp_red,
  // Loop current and tuning
  output logic [15:0]      loop_ua,
  output logic [3:0]       echo_gain,
  output logic             tune_done,
  // Teach status
  output logic             teach_active,
  output logic             zero_stored,
  output logic             end_stored,
  output logic [15:0]      zero_point,
  output logic [15:0]      end_point
);
  import ptsl_pkg::*;

  typedef struct packed {
    ptsl_state_e      st;      // Sequencer state
    logic [31:0]      tmr;     // Phase timer
    logic [1:0]       deb;     // Debounced contacts, bit 0 zero, bit 1 end
    logic [1:0][31:0] dcnt;    // Debounce counters
    logic [15:0]      zero_pt; // Taught zero point
    logic [15:0]      end_pt;  // Taught end point
    logic [3:0]       gain;    // Echo gain
    logic             tuned;   // Tuning finished
    logic             zst;     // Zero stored pulse
    logic             est;     // End stored pulse
    logic [15:0]      cur;     // Loop current
    logic             lg;      // Lamp green
    logic             ly;      // Lamp yellow
    logic             lr;      // Lamp red
    logic             ta;      // Teach window open, registered so the pin is a flop
    logic             go;      // Divider start
    logic [29:0]      num;     // Scaled offset into range
    logic [15:0]      den;     // Range width
  } ptsl_teach_s;

  ptsl_teach_s r, next_r;
  logic        in_range;       // Element inside taught range
  logic        below;          // Element beyond the zero side
  logic        div_ready;
  logic        div_done;
  logic [29:0] div_q;
  logic [1:0]  raw;

  assign raw      = {end_contact, zero_contact};
  assign below    = element_pos < r.zero_pt;
  assign in_range = !below && (element_pos <= r.end_pt);

  // ----------------------------------------------------------------
  // Scaling divider
  // ----------------------------------------------------------------
  ptsl_divider u_div (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .start    (r.go),
    .dividend (r.num),
    .divisor  (r.den),
    .ready    (div_ready),
    .done     (div_done),
    .quotient (div_q)
  );

  // ----------------------------------------------------------------
  // Next state: debounce, tuning, teach sequencer, lamp and current
  // ----------------------------------------------------------------
  always_comb begin
    next_r     = r;
    next_r.zst = 1'b0;
    next_r.est = 1'b0;
    next_r.tmr = r.tmr + 32'h1;
    // A contact changes only after staying changed for the settle time
    for (int i = 0; i < 2; i++) begin
      if (raw[i] == r.deb[i]) begin
        next_r.dcnt[i] = 32'h0;
      end else if (r.dcnt[i] >= 32'(DEBOUNCE_CYCLES - 1)) begin
        next_r.dcnt[i] = 32'h0;
        next_r.deb[i]  = raw[i];
      end else begin
        next_r.dcnt[i] = r.dcnt[i] + 32'h1;
      end
    end
    case (r.st)
      PTSL_TUNE: begin
        // Raise gain until the echo is strong enough, then run
        if (r.tmr >= 32'(TUNE_STEP_CYC - 1)) begin
          next_r.tmr = 32'h0;
          if (echo_level >= TUNE_TARGET || r.gain == GAIN_MAX) begin
            next_r.tuned = 1'b1;
            next_r.st    = PTSL_IDLE;
          end else begin
            next_r.gain = r.gain + 4'h1;
          end
        end
      end
      PTSL_IDLE: begin
        // A floating teach line keeps the sequencer here
        next_r.tmr = 32'h0;
        if (r.deb[0]) begin
          next_r.st = PTSL_HOLD;
        end
      end
      PTSL_HOLD: begin
        if (!r.deb[0]) begin
          next_r.tmr = 32'h0;
          // Released too early counts as a stray closure
          next_r.st  = (r.tmr >= 32'(HOLD_CYCLES)) ? PTSL_OPEN : PTSL_IDLE;
        end
      end
      PTSL_OPEN: begin
        if (r.deb[0]) begin
          next_r.st = PTSL_DONE;
        end else if (r.tmr >= 32'(OPEN_CYCLES - 1)) begin
          next_r.tmr = 32'h0;
          next_r.st  = PTSL_TEACH;
        end
      end
      PTSL_TEACH: begin
        // Zero wins when both close in the same cycle
        if (r.deb[0]) begin
          next_r.zero_pt = element_pos;
          next_r.zst     = 1'b1;
          next_r.st      = PTSL_DONE;
        end else if (r.deb[1]) begin
          next_r.end_pt = element_pos;
          next_r.est    = 1'b1;
          next_r.st     = PTSL_DONE;
        end else if (r.tmr >= 32'(WINDOW_CYCLES - 1)) begin
          next_r.st = PTSL_IDLE;
        end
      end
      PTSL_DONE: begin
        // Wait for both contacts open so the closure does not re-arm
        next_r.tmr = 32'h0;
        if (r.deb == 2'b00) begin
          next_r.st = PTSL_IDLE;
        end
      end
      default: begin
        next_r.st = PTSL_IDLE;
      end
    endcase
    // Flag tracks the state it reports, so it shows teach in the same cycle
    next_r.ta = (next_r.st == PTSL_TEACH);
    // Lamp colour follows the element every cycle
    next_r.lr = !element_seen;
    next_r.lg = element_seen && in_range;
    next_r.ly = element_seen && !in_range;
    // Divider runs back to back on fresh operands
    next_r.go  = div_ready && !r.go;
    // Widen both factors first; a 16 bit product would lose the offset
    next_r.num = 30'({14'h0, element_pos - r.zero_pt} * {14'h0, CUR_SPAN_UA});
    next_r.den = r.end_pt - r.zero_pt;
    if (!element_seen || element_blind) begin
      next_r.cur = CUR_BLIND_UA;
    end else if (below) begin
      next_r.cur = CUR_BELOW_UA;
    end else if (!in_range) begin
      next_r.cur = CUR_ABOVE_UA;
    end else if (div_done) begin
      // Quotient lags position by one division, about 32 cycles
      next_r.cur = (div_q > 30'(CUR_SPAN_UA)) ? (CUR_MIN_UA + CUR_SPAN_UA)
                 : (CUR_MIN_UA + div_q[15:0]);
    end else if (r.cur < CUR_MIN_UA || r.cur > CUR_MIN_UA + CUR_SPAN_UA) begin
      next_r.cur = CUR_MIN_UA;
    end
  end

  // State register; power cycling is the only reset
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      r         <= '0;
      r.st      <= PTSL_TUNE;
      r.zero_pt <= ZERO_RST;
      r.end_pt  <= END_RST;
      r.gain    <= GAIN_RST;
      r.cur     <= CUR_BLIND_UA;
      r.lr      <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign lamp_green   = r.lg;
  assign lamp_yellow  = r.ly;
  assign lamp_red     = r.lr;
  assign loop_ua      = r.cur;
  assign echo_gain    = r.gain;
  assign tune_done    = r.tuned;
  assign teach_active = r.ta;
  assign zero_stored  = r.zst;
  assign end_stored   = r.est;
  assign zero_point   = r.zero_pt;
  assign end_point    = r.end_pt;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  teach_entry_a: assert property ($rose(teach_active) |->
    $past(r.st) == PTSL_OPEN && $past(r.tmr) == 32'(OPEN_CYCLES - 1))
    else $error("teach entered without full release time");
  arm_hold_a: assert property (r.st == PTSL_HOLD && next_r.st == PTSL_OPEN |->
    r.tmr >= 32'(HOLD_CYCLES))
    else $error("armed before hold time");
  zero_store_a: assert property (zero_stored |->
    $past(teach_active) && $past(r.deb[0]) && $stable(end_point))
    else $error("zero stored outside teach or end changed");
  end_store_a: assert property (end_stored |->
    $past(teach_active) && !$past(r.deb[0]) && $stable(zero_point))
    else $error("end stored wrongly or zero changed");
  window_out_a: assert property (teach_active && r.tmr == 32'(WINDOW_CYCLES - 1)
    && r.deb == 2'b00 |=> r.st == PTSL_IDLE && !zero_stored && !end_stored)
    else $error("window timeout did not abandon teach");
  lamp_red_a: assert property (!element_seen |=> lamp_red && !lamp_green && !lamp_yellow)
    else $error("red lamp not shown without element");
  lamp_col_a: assert property (element_seen |=>
    !lamp_red && (lamp_green != lamp_yellow) && (lamp_green == $past(in_range)))
    else $error("lamp colour does not match range");
  blind_cur_a: assert property (!element_seen || element_blind |=> loop_ua == CUR_BLIND_UA)
    else $error("blind current code missing");
  out_cur_a: assert property (element_seen && !element_blind && !in_range |=>
    loop_ua == ($past(below) ? CUR_BELOW_UA : CUR_ABOVE_UA))
    else $error("out of range current code wrong");
  span_cur_a: assert property (element_seen && !element_blind && in_range |=>
    loop_ua >= CUR_MIN_UA && loop_ua <= CUR_MIN_UA + CUR_SPAN_UA)
    else $error("in range current outside span");
  tune_end_a: assert property ($rose(tune_done) |->
    $past(echo_level) >= TUNE_TARGET || echo_gain == GAIN_MAX)
    else $error("tuning ended early");

  zero_teach_c: cover property (zero_stored);
  end_teach_c:  cover property (end_stored);
  timeout_c:    cover property (teach_active ##1 r.st == PTSL_IDLE);
  yellow_c:     cover property (lamp_yellow && loop_ua == CUR_ABOVE_UA);

endmodule : ptsl_teach

// file: verilog/ptsl_pkg.sv
package ptsl_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ        = 100000;                 // 100 MHz mclk
  localparam int HOLD_MS        = 4000;                   // Contact closed to arm
  localparam int OPEN_MS        = 1000;                   // Contact open to enter teach
  localparam int WINDOW_MS      = 5000;                   // Teach closure window
  localparam int DEBOUNCE_MS    = 10;                     // Contact settle time
  localparam int TUNE_STEP_US   = 10;                     // Gain settle per tuning step
  localparam int HOLD_CYC       = HOLD_MS * CLK_KHZ;      // Least time, exact
  localparam int OPEN_CYC       = OPEN_MS * CLK_KHZ;
  localparam int WINDOW_CYC     = WINDOW_MS * CLK_KHZ;    // Longest time, exact
  localparam int DEBOUNCE_CYC   = DEBOUNCE_MS * CLK_KHZ;
  localparam int TUNE_STEP_CYC  = (TUNE_STEP_US * CLK_KHZ + 999) / 1000;

  // ----------------------------------------------------------------
  // Loop current codes in microamps
  // ----------------------------------------------------------------
  localparam logic [15:0] CUR_BLIND_UA = 16'h0ed8;        // 3800 uA
  localparam logic [15:0] CUR_BELOW_UA = 16'h0f3c;        // 3900 uA
  localparam logic [15:0] CUR_MIN_UA   = 16'h0fa0;        // 4000 uA
  localparam logic [15:0] CUR_SPAN_UA  = 16'h3e80;        // 16000 uA
  localparam logic [15:0] CUR_ABOVE_UA = 16'h4e84;        // 20100 uA

  // ----------------------------------------------------------------
  // Reset values and tuning
  // ----------------------------------------------------------------
  localparam logic [15:0] ZERO_RST     = 16'h0000;        // Untaught zero point
  localparam logic [15:0] END_RST      = 16'hffff;        // Untaught end point
  localparam logic [3:0]  GAIN_RST     = 4'h0;            // Lowest gain at power-up
  localparam logic [3:0]  GAIN_MAX     = 4'hf;
  localparam logic [7:0]  TUNE_TARGET  = 8'h80;           // Wanted echo amplitude

  // ----------------------------------------------------------------
  // Sequencer states, Gray along tune, idle, hold, open, teach, done
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PTSL_TUNE  = 3'h4,
    PTSL_IDLE  = 3'h0,
    PTSL_HOLD  = 3'h1,
    PTSL_OPEN  = 3'h3,
    PTSL_TEACH = 3'h2,
    PTSL_DONE  = 3'h6
  } ptsl_state_e;

endpackage : ptsl_pkg

// file: verilog/ptsl_divider.sv
`timescale 1ns/100ps
// Serial restoring divider, one quotient bit per clock
module ptsl_divider (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // Request
  input  wire logic        start,
  input  wire logic [29:0] dividend,
  input  wire logic [15:0] divisor,
  // Answer
  output logic             ready,
  output logic             done,
  output logic [29:0]      quotient
);
  import ptsl_pkg::*;

  typedef struct packed {
    logic [16:0] rem;   // Partial remainder
    logic [29:0] quo;   // Dividend shifting out, quotient shifting in
    logic [15:0] den;   // Latched divisor
    logic [4:0]  cnt;   // Steps left
    logic        busy;  // Division running
    logic        done;  // Result pulse
  } ptsl_div_s;

  ptsl_div_s r, next_r;
  logic [16:0] trial;   // Shifted remainder for this step

  // ----------------------------------------------------------------
  // Step logic
  // ----------------------------------------------------------------
  always_comb begin
    next_r      = r;
    next_r.done = 1'b0;
    trial       = {r.rem[15:0], r.quo[29]};
    if (!r.busy && start) begin
      // Zero divisor yields all ones, which the caller clamps
      next_r.rem  = 17'h00000;
      next_r.quo  = dividend;
      next_r.den  = divisor;
      next_r.cnt  = 5'h1e;
      next_r.busy = 1'b1;
    end else if (r.busy) begin
      if (trial >= {1'b0, r.den}) begin
        next_r.rem = trial - {1'b0, r.den};
        next_r.quo = {r.quo[28:0], 1'b1};
      end else begin
        next_r.rem = trial;
        next_r.quo = {r.quo[28:0], 1'b0};
      end
      next_r.cnt = r.cnt - 5'h01;
      if (r.cnt == 5'h01) begin
        next_r.busy = 1'b0;
        next_r.done = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign ready    = ~r.busy;
  assign done     = r.done;
  assign quotient = r.quo;

endmodule : ptsl_divider

// file: test/ptsl_operator.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Teach line operator: wire bridge or adapter buttons
// ----------------------------------------------------------------
module ptsl_operator (
  // Clock
  input  wire logic mclk,
  // Contacts towards the sensor, high while closed
  output logic      zero_contact,
  output logic      end_contact
);
  // Line left open unless a closure is commanded, so no stray teach
  initial begin
    zero_contact = 1'b0;
    end_contact  = 1'b0;
  end

  // Close one contact for a number of cycles, then open both again
  task automatic close_for(input bit use_end, input int cycles);
    @(negedge mclk);
    if (use_end) begin
      end_contact = 1'b1;
    end else begin
      zero_contact = 1'b1;
    end
    repeat (cycles) @(negedge mclk);
    zero_contact = 1'b0;
    end_contact  = 1'b0;
  endtask : close_for

  // Entry pattern: closed for the arm time, then open for the release time
  task automatic enter_teach(input int hold, input int open);
    close_for(1'b0, hold);
    repeat (open) @(negedge mclk);
  endtask : enter_teach
endmodule : ptsl_operator

// file: test/test_position_teach_and_status_logic.sv
`timescale 1ns/100ps
module test_position_teach_and_status_logic;
  import ptsl_pkg::*;
  // ----------------------------------------------------------------
  // Short counts so the run stays brief
  // ----------------------------------------------------------------
  localparam int HOLD = 20;
  localparam int OPEN = 10;
  localparam int WIN  = 30;
  localparam int DEB  = 2;
  localparam int CEILING = 20000;  // Both tunings plus teach runs
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        mclk, rst_b, element_seen, element_blind;
  logic        zero_contact, end_contact;
  logic [15:0] element_pos;
  logic [7:0]  echo_level;
  logic        lamp_green, lamp_yellow, lamp_red, tune_done;
  logic        teach_active, zero_stored, end_stored;
  logic [15:0] loop_ua, zero_point, end_point;
  logic [3:0]  echo_gain;
  int          n_mismatch, checks, cycles, zero_cnt, end_cnt;

  // Echo grows with gain; target reached at gain 3
  assign echo_level = (echo_gain >= 4'h3) ? 8'h90 : 8'h20;

  ptsl_teach #(.HOLD_CYCLES(HOLD), .OPEN_CYCLES(OPEN), .WINDOW_CYCLES(WIN),
    .DEBOUNCE_CYCLES(DEB)) dut (
    .mclk(mclk), .rst_b(rst_b), .zero_contact(zero_contact), .end_contact(end_contact),
    .element_seen(element_seen), .element_blind(element_blind),
    .element_pos(element_pos), .echo_level(echo_level), .lamp_green(lamp_green),
    .lamp_yellow(lamp_yellow), .lamp_red(lamp_red), .loop_ua(loop_ua),
    .echo_gain(echo_gain), .tune_done(tune_done), .teach_active(teach_active),
    .zero_stored(zero_stored), .end_stored(end_stored), .zero_point(zero_point),
    .end_point(end_point));

  ptsl_operator op (.mclk(mclk), .zero_contact(zero_contact), .end_contact(end_contact));

  // Clock and cycle ceiling; a hang counts as a mismatch
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (zero_stored === 1'b1) zero_cnt++;
    if (end_stored === 1'b1) end_cnt++;
    if (cycles == CEILING) begin
      n_mismatch++;
      end_sim();
    end
  end
  // ----------------------------------------------------------------
  // Compare and helper tasks
  // ----------------------------------------------------------------
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk_val
  task automatic chk_lamp(input logic [2:0] exp);
    chk_val({13'h0, lamp_green, lamp_yellow, lamp_red}, {13'h0, exp}, "lamp");
  endtask : chk_lamp
  // Wait for tuning with a bound, then check the gain it settled on
  task automatic wait_tune();
    int i;
    for (i = 0; i < 6000 && tune_done !== 1'b1; i++) @(negedge mclk);
    chk_val({15'h0, tune_done}, 16'h1, "tune done");
    chk_val({12'h0, echo_gain}, 16'h3, "gain");
  endtask : wait_tune
  // Place element, let the division settle, compare lamp and current
  task automatic look(input logic [15:0] pos, input logic [2:0] lamp, input logic [15:0] ua);
    @(negedge mclk);
    element_pos = pos;
    repeat (100) @(negedge mclk);
    chk_lamp(lamp);
    chk_val(loop_ua, ua, "loop current");
  endtask : look
  // Full teach: entry pattern, closure, one store pulse, other point kept
  task automatic teach(input bit use_end, input logic [15:0] pos);
    int z0, e0, i;
    logic [15:0] other;
    z0 = zero_cnt;
    e0 = end_cnt;
    other = use_end ? zero_point : end_point;
    element_pos = pos;
    op.enter_teach(HOLD + DEB + 4, OPEN + DEB + 2);
    for (i = 0; i < 10 && teach_active !== 1'b1; i++) @(negedge mclk);
    chk_val({15'h0, teach_active}, 16'h1, "teach mode");
    op.close_for(use_end, DEB + 4);
    repeat (4) @(negedge mclk);
    chk_val(16'(zero_cnt - z0), {15'h0, !use_end}, "zero pulses");
    chk_val(16'(end_cnt - e0), {15'h0, use_end}, "end pulses");
    chk_val(use_end ? end_point : zero_point, pos, "taught point");
    chk_val(use_end ? zero_point : end_point, other, "kept point");
    repeat (10) @(negedge mclk);
  endtask : teach
  // Entry pattern without closure, or with a short hold: nothing stored
  task automatic no_store(input int hold);
    int z0, e0;
    logic [15:0] zp, ep;
    z0 = zero_cnt;
    e0 = end_cnt;
    zp = zero_point;
    ep = end_point;
    op.enter_teach(hold, OPEN + DEB + 2);
    // A long enough hold must open the window; a short one must not
    chk_val({15'h0, teach_active}, {15'h0, hold > HOLD}, "teach entry");
    repeat (WIN + 10) @(negedge mclk);
    chk_val({15'h0, teach_active}, 16'h0, "teach left");
    chk_val(16'(zero_cnt + end_cnt - z0 - e0), 16'h0, "no pulses");
    chk_val(zero_point, zp, "zero kept");
    chk_val(end_point, ep, "end kept");
  endtask : no_store
  // Supply reset mid-run: reset values, then tuning again unaided
  task automatic power_cycle();
    @(negedge mclk);
    rst_b = 1'b0;
    repeat (2) @(negedge mclk);
    chk_lamp(3'b001);
    chk_val(loop_ua, CUR_BLIND_UA, "reset current");
    chk_val(end_point, END_RST, "reset end");
    // Tuning must restart from scratch, else the re-tune below proves nothing
    chk_val({15'h0, tune_done}, 16'h0, "reset tune flag");
    chk_val({12'h0, echo_gain}, {12'h0, GAIN_RST}, "reset gain");
    rst_b = 1'b1;
    wait_tune();
  endtask : power_cycle
  // Closing report
  task automatic end_sim();
    if (n_mismatch == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    element_seen = 1'b1;
    element_blind = 1'b0;
    element_pos = 16'h8000;
    repeat (4) @(negedge mclk);
    rst_b = 1'b1;
    wait_tune();
    look(16'h8000, 3'b100, 16'h2ee0);
    element_seen = 1'b0;
    look(16'h8000, 3'b001, CUR_BLIND_UA);
    element_seen = 1'b1;
    element_blind = 1'b1;
    look(16'h8000, 3'b100, CUR_BLIND_UA);
    element_blind = 1'b0;
    teach(1'b0, 16'h1000);
    teach(1'b1, 16'h9000);
    look(16'h0800, 3'b010, CUR_BELOW_UA);
    look(16'ha000, 3'b010, CUR_ABOVE_UA);
    look(16'h5000, 3'b100, 16'h2ee0);
    look(16'h1000, 3'b100, CUR_MIN_UA);
    no_store(HOLD + DEB + 4);
    no_store(HOLD / 2);
    power_cycle();
    end_sim();
  end
endmodule : test_position_teach_and_status_logic
